// file: char_lcd_consts.vh
// Constants of the character display instruction port.
`ifndef CHAR_LCD_CONSTS_VH
`define CHAR_LCD_CONSTS_VH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS       4
`define EXEC_TIME_NS        40000
`define EXEC_CYCLES         (`EXEC_TIME_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Register port byte offsets
// ----------------------------------------------------------------------
`define REG_STATUS          8'h00
`define REG_CONTROL         8'h04
`define REG_GLYPH_SEL       8'h08
`define REG_GLYPH_ROW       8'h0C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ST_AC_LSB           0
`define ST_BUSY_BIT         7
`define ST_WIDTH_BIT        8
`define ST_LINES_BIT        9
`define ST_FONT_BIT         10
`define ST_LOCKED_BIT       11
`define ST_GLYPH_SEL_BIT    12
`define ST_DUTY16_BIT       13
`define ST_INC_BIT          14
`define ST_SHIFT_BIT        15
`define CTL_CURSOR_BIT      0
`define GSEL_ROW_LSB        8
`define FS_WIDTH_BIT        4
`define FS_LINES_BIT        3
`define FS_FONT_BIT         2
`define CUR_ROW             3'h7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_WIDTH           1'b1
`define RST_LINES           1'b1
`define RST_FONT            1'b0
`define RST_INC             1'b1
`define RST_CTL             1'b0

`endif

// file: char_lcd_instruction_port.v
// Instruction and data port of the character display controller.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`include "char_lcd_consts.vh"

module char_lcd_instruction_port #(
    parameter EXEC_CYCLES = `EXEC_CYCLES,
    parameter BUSY_W      = 16
) (
    input  wire        MCLK,
    input  wire        RESET_N,
    input  wire        E,
    input  wire        REGISTER_SELECT,
    input  wire        RW,
    input  wire [7:0]  DB_IN,
    output reg  [7:0]  DB_OUT,
    output reg         DB_OE,
    output reg         SHIFT_LEFT,
    output reg         SHIFT_RIGHT,
    input  wire [7:0]  ADDR,
    input  wire [31:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [31:0] RDATA
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Steps the pointer by one in the given direction: up when inc is set, down otherwise.
    function [6:0] step_ptr;
        input [6:0] ptr;
        input       inc;
        begin
            step_ptr = inc ? ptr + 7'h01 : ptr - 7'h01;
        end
    endfunction

    // Picks the byte or nibble presented on the bus.
    function [7:0] bus_view;
        input [7:0] val;
        input       wide;
        input       phase;
        begin
            if (wide)
                bus_view = val;
            else if (!phase)
                bus_view = {val[7:4], 4'h0};
            else
                bus_view = {val[3:0], 4'h0};
        end
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg  [2:0]        e_sync_ff;
    reg  [1:0]        rs_sync_ff;
    reg  [1:0]        rw_sync_ff;
    reg  [7:0]        db_s1_ff;
    reg  [7:0]        db_s2_ff;
    reg               bus_width_select_ff;
    reg               lines_ff;
    reg               font_ff;
    reg               func_seen_ff;
    reg               locked_ff;
    reg               glyph_sel_ff;
    reg               inc_ff;
    reg               shift_en_ff;
    reg               nib_phase_ff;
    reg  [3:0]        hi_nib_ff;
    reg  [6:0]        address_pointer_ff;
    reg  [7:0]        data_register_ff;
    reg  [BUSY_W-1:0] busy_cnt_ff;
    reg               cursor_en_ff;
    reg  [10:0]       glyph_pick_ff;
    reg  [7:0]        glyph_ram [0:63];
    reg  [7:0]        display_ram [0:127];
    wire              e_fall;
    wire              busy_flag;
    wire              full_byte;
    wire [7:0]        rx_byte;
    wire              do_instr;
    wire              do_wr;
    wire              do_rd;
    wire [6:0]        stepped;
    reg  [6:0]        nxt_ptr;
    reg               nxt_sel;
    reg               nxt_prefetch;
    wire [7:0]        prefetch_val;
    wire [5:0]        glyph_idx;
    wire [4:0]        glyph_dots;
    wire [7:0]        status_byte;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------

    // Every display bus pin passes two flops before the logic looks at it; the register port is used unsynchronised.
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            e_sync_ff  <= 3'h0;
            rs_sync_ff <= 2'h0;
            rw_sync_ff <= 2'h0;
            db_s1_ff   <= 8'h00;
            db_s2_ff   <= 8'h00;
        end else begin
            e_sync_ff  <= {e_sync_ff[1:0], E};
            rs_sync_ff <= {rs_sync_ff[0], REGISTER_SELECT};
            rw_sync_ff <= {rw_sync_ff[0], RW};
            db_s1_ff   <= DB_IN;
            db_s2_ff   <= db_s1_ff;
        end
    end

    // Falling enable edge seen on the synchronised copy.
    assign e_fall = e_sync_ff[2] & ~e_sync_ff[1];

    // ------------------------------------------------------------------
    // Byte assembly and decode
    // ------------------------------------------------------------------
    assign busy_flag = (busy_cnt_ff != {BUSY_W{1'b0}});
    assign full_byte = e_fall & (bus_width_select_ff | nib_phase_ff);
    assign rx_byte   = bus_width_select_ff ? db_s2_ff : {hi_nib_ff, db_s2_ff[7:4]};
    // Writes and data reads are ignored while busy.
    assign do_instr  = full_byte & ~rs_sync_ff[1] & ~rw_sync_ff[1] & ~busy_flag;
    assign do_wr     = full_byte & rs_sync_ff[1] & ~rw_sync_ff[1] & ~busy_flag;
    assign do_rd     = full_byte & rs_sync_ff[1] & rw_sync_ff[1] & ~busy_flag;
    assign stepped   = step_ptr(address_pointer_ff, inc_ff);

    // Next pointer, RAM selection and whether the read latch reloads.
    always @* begin
        nxt_ptr      = address_pointer_ff;
        nxt_sel      = glyph_sel_ff;
        nxt_prefetch = 1'b0;
        if (do_instr) begin
            casez (rx_byte)
                8'b1???_????: begin
                    nxt_ptr      = rx_byte[6:0];
                    nxt_sel      = 1'b0;
                    nxt_prefetch = 1'b1;
                end
                8'b01??_????: begin
                    nxt_ptr      = {1'b0, rx_byte[5:0]};
                    nxt_sel      = 1'b1;
                    nxt_prefetch = 1'b1;
                end
                8'b0001_0???: begin
                    nxt_ptr      = step_ptr(address_pointer_ff, rx_byte[2]);
                    nxt_sel      = 1'b0;
                    nxt_prefetch = 1'b1;
                end
                default: begin
                    nxt_ptr = address_pointer_ff;
                end
            endcase
        end else if (do_wr) begin
            nxt_ptr = stepped;
        end else if (do_rd) begin
            nxt_ptr      = stepped;
            nxt_prefetch = 1'b1;
        end
    end

    // Contents of the newly addressed cell for the read latch.
    assign prefetch_val = nxt_sel ? glyph_ram[nxt_ptr[5:0]] : display_ram[nxt_ptr];

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------

    // Function set, entry mode, pointer, read latch and busy timer.
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bus_width_select_ff <= `RST_WIDTH;
            lines_ff            <= `RST_LINES;
            font_ff             <= `RST_FONT;
            func_seen_ff        <= 1'b0;
            locked_ff           <= 1'b0;
            glyph_sel_ff        <= 1'b0;
            inc_ff              <= `RST_INC;
            shift_en_ff         <= 1'b0;
            nib_phase_ff        <= 1'b0;
            hi_nib_ff           <= 4'h0;
            address_pointer_ff  <= 7'h00;
            data_register_ff    <= 8'h00;
            busy_cnt_ff         <= {BUSY_W{1'b0}};
            SHIFT_LEFT          <= 1'b0;
            SHIFT_RIGHT         <= 1'b0;
        end else begin
            SHIFT_LEFT  <= 1'b0;
            SHIFT_RIGHT <= 1'b0;
            // Nibble phase advances on every enable fall in narrow mode.
            if (e_fall && !bus_width_select_ff) begin
                nib_phase_ff <= ~nib_phase_ff;
                if (!nib_phase_ff)
                    hi_nib_ff <= db_s2_ff[7:4];
            end
            address_pointer_ff <= nxt_ptr;
            glyph_sel_ff       <= nxt_sel;
            // Write leaves the latch stale; only set, cursor shift and read reload it.
            if (nxt_prefetch)
                data_register_ff <= prefetch_val;
            if (busy_flag)
                busy_cnt_ff <= busy_cnt_ff - {{(BUSY_W-1){1'b0}}, 1'b1};
            if (do_instr || do_wr || do_rd)
                busy_cnt_ff <= EXEC_CYCLES[BUSY_W-1:0];
            if (do_instr) begin
                if (rx_byte[7:5] == 3'b001) begin
                    func_seen_ff        <= 1'b1;
                    bus_width_select_ff <= rx_byte[`FS_WIDTH_BIT];
                    nib_phase_ff        <= 1'b0;
                    if (!locked_ff) begin
                        lines_ff <= rx_byte[`FS_LINES_BIT];
                        font_ff  <= rx_byte[`FS_FONT_BIT];
                    end
                end else begin
                    if (!func_seen_ff)
                        locked_ff <= 1'b1;
                    if (rx_byte[7:2] == 6'b000001) begin
                        inc_ff      <= rx_byte[1];
                        shift_en_ff <= rx_byte[0];
                    end
                    if (rx_byte[7:3] == 5'b00011) begin
                        SHIFT_LEFT  <= ~rx_byte[2];
                        SHIFT_RIGHT <= rx_byte[2];
                    end
                end
            end
            // Entry-mode display shift after a display RAM write only.
            if (do_wr && !glyph_sel_ff && shift_en_ff) begin
                SHIFT_LEFT  <= inc_ff;
                SHIFT_RIGHT <= ~inc_ff;
            end
        end
    end

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------

    // Data writes land in the RAM picked by the last address set; a cursor shift picks display RAM.
    always @(posedge MCLK) begin
        if (do_wr) begin
            if (glyph_sel_ff)
                glyph_ram[address_pointer_ff[5:0]] <= rx_byte;
            else
                display_ram[address_pointer_ff] <= rx_byte;
        end
    end

    // ------------------------------------------------------------------
    // Bus read drive
    // ------------------------------------------------------------------
    assign status_byte = {busy_flag, address_pointer_ff};

    // Read data stand on the pins while enable is high.
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            DB_OUT <= 8'h00;
            DB_OE  <= 1'b0;
        end else if (e_sync_ff[1] && rw_sync_ff[1]) begin
            DB_OE <= 1'b1;
            if (rs_sync_ff[1])
                DB_OUT <= bus_view(data_register_ff, bus_width_select_ff, nib_phase_ff);
            else
                DB_OUT <= bus_view(status_byte, bus_width_select_ff, nib_phase_ff);
        end else begin
            DB_OUT <= 8'h00;
            DB_OE  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Glyph row lookup
    // ------------------------------------------------------------------
    // Code bits 0-2 form the upper glyph address, code bit 3 is dropped.
    assign glyph_idx  = {glyph_pick_ff[2:0], glyph_pick_ff[`GSEL_ROW_LSB+2:`GSEL_ROW_LSB]};
    // Only custom codes light dots; the cursor row ORs in the cursor.
    assign glyph_dots = (glyph_pick_ff[7:4] != 4'h0) ? 5'h00 :
                        (glyph_ram[glyph_idx][4:0] |
                        ((cursor_en_ff && glyph_pick_ff[10:8] == `CUR_ROW) ? 5'h1F : 5'h00));

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------

    // Software writes to the cursor control and glyph selector.
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cursor_en_ff  <= `RST_CTL;
            glyph_pick_ff <= 11'h000;
        end else if (WR) begin
            if (ADDR == `REG_CONTROL)
                cursor_en_ff <= WDATA[`CTL_CURSOR_BIT];
            if (ADDR == `REG_GLYPH_SEL)
                glyph_pick_ff <= WDATA[10:0];
        end
    end

    // Read data stand for one cycle after the strobe; unmapped read zero.
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA <= 32'h0000_0000;
        end else if (RD) begin
            case (ADDR)
                `REG_STATUS:    RDATA <= {16'h0000, shift_en_ff, inc_ff,
                                          lines_ff & ~font_ff, glyph_sel_ff, locked_ff,
                                          font_ff, lines_ff, bus_width_select_ff,
                                          status_byte};
                `REG_CONTROL:   RDATA <= {31'h0000_0000, cursor_en_ff};
                `REG_GLYPH_SEL: RDATA <= {21'h00_0000, glyph_pick_ff};
                `REG_GLYPH_ROW: RDATA <= {27'h000_0000, glyph_dots};
                default:        RDATA <= 32'h0000_0000;
            endcase
        end else begin
            RDATA <= 32'h0000_0000;
        end
    end

endmodule // char_lcd_instruction_port

// file: char_lcd_instruction_port_assertions.sv
// Concurrent checks on the pins and register port of the display instruction port.
`timescale 1ns/10ps
module char_lcd_instruction_port_assertions #(
    parameter EXEC_CYCLES = 20,
    parameter BUSY_W      = 16
) (
    input wire        MCLK,
    input wire        RESET_N,
    input wire        E,
    input wire        REGISTER_SELECT,
    input wire        RW,
    input wire [7:0]  DB_IN,
    input wire [7:0]  DB_OUT,
    input wire        DB_OE,
    input wire        SHIFT_LEFT,
    input wire        SHIFT_RIGHT,
    input wire [7:0]  ADDR,
    input wire [31:0] WDATA,
    input wire        WR,
    input wire        RD,
    input wire [31:0] RDATA
);
    // ----------------------------------------
    // Clocking and strobe sequences
    // ----------------------------------------
    default clocking dc @(posedge MCLK);
    endclocking
    default disable iff (!RESET_N);

    // A read strobe opens; the lines must be taken and later let go within a few cycles.
    sequence s_read_open;
        $rose(E) && RW;
    endsequence
    sequence s_drive_soon;
        ##[1:4] DB_OE;
    endsequence
    sequence s_release_soon;
        ##[1:4] !DB_OE;
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_drive_on_read: assert property (s_read_open |-> s_drive_soon)
        else $error("data lines not driven in a read strobe");
    a_release_after_fall: assert property ($fell(E) |-> s_release_soon)
        else $error("data lines held after the strobe fell");
    a_drive_reads_only: assert property (DB_OE |-> RW)
        else $error("data lines driven during a write");
    a_shift_writes_only: assert property (SHIFT_LEFT || SHIFT_RIGHT |-> !RW)
        else $error("display shift during a read");
    a_shift_one_way: assert property (!(SHIFT_LEFT && SHIFT_RIGHT))
        else $error("shift left and right together");
    a_shift_single: assert property (SHIFT_LEFT |=> !SHIFT_LEFT)
        else $error("shift request longer than one cycle");
    a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
        else $error("read data present without a read");
    a_unmapped_zero: assert property (RD && ADDR > 8'h0C |=> RDATA == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_glyph_five_dots: assert property (RD && ADDR == 8'h0C |=> RDATA[31:5] == 27'h0)
        else $error("glyph row wider than five dots");
    a_duty_follows: assert property (RD && ADDR == 8'h00 |=>
        RDATA[13] == (RDATA[9] && !RDATA[10])) else $error("duty flag wrong");
endmodule // char_lcd_instruction_port_assertions

// file: lcd_host_model.sv
// Host processor model that drives the display's parallel bus.
`timescale 1ns/10ps
module lcd_host_model (
    input  wire       clk,
    input  wire [7:0] db_out,
    output reg        e,
    output reg        rs,
    output reg        rw,
    output reg  [7:0] db
);
    reg wide;

    // Bus starts idle, eight lines assumed as after reset.
    initial begin
        e    = 1'b0;
        rs   = 1'b0;
        rw   = 1'b0;
        db   = 8'h00;
        wide = 1'b1;
    end

    // One strobe: lines settle, strobe high, strobe low, lines held past the fall.
    task cyc(input r_s, input r_w, input [7:0] d, output [7:0] q);
        @(posedge clk);
        rs <= r_s;
        rw <= r_w;
        db <= r_w ? ~db : d; // Released lines do not keep the old value.
        repeat (4) @(posedge clk);
        e <= 1'b1;
        repeat (6) @(posedge clk);
        q = db_out;
        e <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // A whole byte, split into high then low nibble on the four-line bus.
    task xfer(input r_s, input r_w, input [7:0] d, output [7:0] q);
        reg [7:0] hi;
        reg [7:0] lo;
        if (wide)
            cyc(r_s, r_w, d, q);
        else begin
            cyc(r_s, r_w, {d[7:4], 4'h0}, hi);
            cyc(r_s, r_w, {d[3:0], 4'h0}, lo);
            q = {hi[7:4], lo[7:4]};
        end
    endtask

    // Reads status until the busy flag clears, with a bound on the wait.
    task poll;
        reg [7:0] s;
        integer   n;
        s = 8'h80;
        for (n = 0; n < 60 && s[7]; n = n + 1)
            xfer(1'b0, 1'b1, 8'h00, s);
    endtask

    // Writes a byte, following any bus width change that it makes.
    task wr(input r_s, input [7:0] d, input wait_ready);
        reg [7:0] q;
        xfer(r_s, 1'b0, d, q);
        if (!r_s && d[7:5] == 3'b001)
            wide = d[4];
        if (wait_ready)
            poll;
    endtask

    // Reads a byte, then waits until the device is ready again.
    task rd(input r_s, output [7:0] q);
        xfer(r_s, 1'b1, 8'h00, q);
        poll;
    endtask
endmodule // lcd_host_model

// file: testbench.sv
// Self-checking bench for the display instruction port.
`timescale 1ns/10ps
module testbench;
    reg         mclk    = 1'b0;
    reg         reset_n = 1'b0;
    reg  [7:0]  addr    = 8'h00;
    reg  [31:0] wdata   = 32'h0000_0000;
    reg         wr      = 1'b0;
    reg         rd      = 1'b0;
    wire        e, rs, rw, db_oe, shl, shr;
    wire [7:0]  db_in, db_out;
    wire [31:0] rdata;
    integer     failures = 0;
    integer     checked  = 0;
    integer     shifts   = 0;
    integer     rights   = 0;
    integer     i;
    reg  [7:0]  q;
    reg  [31:0] w;
    // Glyph rows: code, row, cursor, expected dots.
    reg  [23:0] rows [0:7] = '{24'h00_0005, 24'h08_0005, 24'h03_2007, 24'h07_5016,
                               24'h01_711F, 24'h01_7010, 24'h11_0000, 24'h06_4109};

    // Clock and shift-request counters.
    always #2 mclk = ~mclk;
    always @(posedge mclk) if (shl === 1'b1) shifts <= shifts + 1;
    always @(posedge mclk) if (shr === 1'b1) rights <= rights + 1;

    char_lcd_instruction_port #(.EXEC_CYCLES(20), .BUSY_W(16)) dut (
        .MCLK(mclk), .RESET_N(reset_n), .E(e), .REGISTER_SELECT(rs), .RW(rw),
        .DB_IN(db_in), .DB_OUT(db_out), .DB_OE(db_oe), .SHIFT_LEFT(shl),
        .SHIFT_RIGHT(shr), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
    lcd_host_model host (.clk(mclk), .db_out(db_out), .e(e), .rs(rs), .rw(rw), .db(db_in));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [7:0] gd(input integer n);
        gd = 8'(n * 37 + 5);
    endfunction
    task check(input [31:0] got, input [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude;
        if (failures == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task reg_wr(input [7:0] a, input [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task reg_rd(input [7:0] a, output [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        d = rdata; // Taken mid-cycle while the answer stands.
    endtask

    // Watchdog cuts a hang short.
    initial begin
        repeat (40000) @(posedge mclk);
        failures = failures + 1;
        conclude;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        host.wr(1'b0, 8'h34, 1'b1);
        reg_rd(8'h00, w);
        check(w, 32'h0000_4500);
        host.wr(1'b0, 8'h38, 1'b1);
        host.wr(1'b0, 8'h40, 1'b1);
        for (i = 0; i < 64; i = i + 1)
            host.wr(1'b1, gd(i), 1'b1);
        reg_rd(8'h00, w);
        check(w, 32'h0000_7340);
        for (i = 0; i < 8; i = i + 1) begin
            reg_wr(8'h04, {31'h0, rows[i][8]});
            reg_wr(8'h08, {21'h0, rows[i][14:12], rows[i][23:16]});
            reg_rd(8'h0C, w);
            check(w, {24'h0, rows[i][7:0]});
        end
        host.wr(1'b0, 8'h7F, 1'b1);
        host.rd(1'b1, q);
        check({24'h0, q}, {24'h0, gd(63)});
        host.wr(1'b0, 8'h41, 1'b1);
        host.rd(1'b1, q);
        check({24'h0, q}, {24'h0, gd(1)});
        host.rd(1'b1, q);
        check({24'h0, q}, {24'h0, gd(2)});
        host.rd(1'b0, q);
        check({24'h0, q}, 32'h0000_0003);
        host.wr(1'b1, 8'hE7, 1'b1);
        host.rd(1'b1, q);
        check({31'h0, q === gd(4)}, 32'h0000_0000);
        host.wr(1'b0, 8'h04, 1'b1);
        host.wr(1'b1, 8'h11, 1'b1);
        host.rd(1'b0, q);
        check({24'h0, q}, 32'h0000_0004);
        // Second reset in mid-run, then reset values and an unmapped place.
        reset_n <= 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        reg_rd(8'h00, w);
        check(w, 32'h0000_6300);
        reg_rd(8'h04, w);
        check(w, 32'h0000_0000);
        reg_rd(8'h10, w);
        check(w, 32'h0000_0000);
        host.wr(1'b0, 8'h06, 1'b1);
        host.wr(1'b0, 8'h34, 1'b1);
        reg_rd(8'h00, w);
        check(w, 32'h0000_6B00);
        // Display memory with shifting entry, then a read after a cursor step.
        host.wr(1'b0, 8'h07, 1'b1);
        host.wr(1'b0, 8'h85, 1'b1);
        host.wr(1'b1, 8'h5A, 1'b1);
        reg_rd(8'h00, w);
        check(w, 32'h0000_EB06);
        check(shifts, 1);
        host.wr(1'b0, 8'h84, 1'b1);
        host.wr(1'b0, 8'h14, 1'b1);
        host.rd(1'b1, q);
        check({24'h0, q}, 32'h0000_005A);
        check(shifts, 1);
        // Decrementing entry with shift: right shift request, pointer steps down.
        host.wr(1'b0, 8'h05, 1'b1);
        host.wr(1'b1, 8'hC3, 1'b1);
        check(rights, 1);
        host.rd(1'b0, q);
        check({24'h0, q}, 32'h0000_0005);
        host.wr(1'b0, 8'h07, 1'b1);
        // Writes while busy are dropped; status shows busy with the pointer.
        host.wr(1'b0, 8'h95, 1'b0);
        host.wr(1'b0, 8'h96, 1'b0);
        host.rd(1'b0, q);
        check({24'h0, q}, 32'h0000_0015);
        host.wr(1'b0, 8'h97, 1'b0);
        host.rd(1'b0, q);
        check({24'h0, q}, 32'h0000_0097);
        // Four-line bus and back.
        host.wr(1'b0, 8'h28, 1'b1);
        reg_rd(8'h00, w);
        check(w, 32'h0000_EA17);
        host.wr(1'b0, 8'hA3, 1'b1);
        host.rd(1'b0, q);
        check({24'h0, q}, 32'h0000_0023);
        host.wr(1'b0, 8'h38, 1'b1);
        reg_rd(8'h00, w);
        check(w, 32'h0000_EB23);
        conclude;
    end
endmodule // testbench

bind char_lcd_instruction_port char_lcd_instruction_port_assertions
    #(.EXEC_CYCLES(EXEC_CYCLES), .BUSY_W(BUSY_W)) chk (.*);
